// *** hdl/edge_flag.sv ***
`timescale 1ns/100ps
module edge_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire logic rise_sel,
	input wire logic arm,
	input wire logic clr,
	output logic flag
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic flag;
	} cell_t;
	cell_t st_reg, st_next;
	logic edge_seen;
	logic set;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin;
		st_next.s2 = st_reg.s1;
		st_next.prev = st_reg.s2;
		edge_seen = rise_sel ? (st_reg.s2 & ~st_reg.prev) : (~st_reg.s2 & st_reg.prev);
		set = arm & edge_seen;
		// set beats a same-cycle clear so no edge is lost
		st_next.flag = set | (st_reg.flag & ~clr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign flag = st_reg.flag;

	a_flag_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
		set |=> st_reg.flag)
		else $error("edge flag missed its edge");
	a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.flag && !clr) |=> st_reg.flag)
		else $error("edge flag dropped without clear");
endmodule

// *** hdl/edge_interrupt_controller.sv ***
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module edge_interrupt_controller
	import eic_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [eic_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] irq_pin,
	input wire logic [7:0] pin_event_pin,
	input wire logic [eic_pkg::INT_N-1:0] periph_req,
	input wire logic insn_done,
	output logic exc_req,
	output eic_pkg::exc_bus_t exc
);
	typedef struct packed {
		exc_state_t fsm;
		logic [2:0] cnt;
		logic [4:0] vec;
		logic mask_i;
		logic [3:0] ien_irq;
		logic [3:0] edge_irq;
		logic [3:0] pmr_irq;
		logic [7:0] ien_pin;
		logic [7:0] edge_pin;
		logic [INT_N-1:0] int_flag;
		logic [INT_N-1:0] ien_int;
		logic [31:0] prdata;
		logic pslverr;
	} ctl_t;

	localparam ctl_t CTL_RESET = '{fsm: S_IDLE, mask_i: CCR_I_RESET, default: '0};

	ctl_t st_reg, st_next;
	logic [3:0] irq_flag;
	logic [7:0] pin_flag;
	logic [3:0] irq_clr;
	logic [7:0] pin_clr;
	logic [INT_N-1:0] int_clr;
	logic [3:0] elig_irq;
	logic pin_any;
	logic [INT_N-1:0] elig_int;
	logic pend_take;
	logic take;
	logic wr;
	logic hit;
	logic [31:0] rd;

	function automatic logic [4:0] pick(input logic [3:0] ei, input logic pa,
		input logic [INT_N-1:0] en);
		logic [4:0] v;
		v = VEC_INT_LAST;
		// scan low priority first so the highest one is written last
		for (int k = INT_N - 1; k >= 0; k--) begin
			if (en[k]) begin
				v = (k < INT_VEC_SPAN) ? VEC_INT0 + 5'(k) : VEC_INT_LAST;
			end
		end
		if (pa) begin
			v = VEC_PIN;
		end
		for (int k = 3; k >= 0; k--) begin
			if (ei[k]) begin
				v = VEC_IRQ0 + 5'(k);
			end
		end
		return v;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : irq_cells
			edge_flag u_irq (
				.pclk(pclk),
				.presetn(presetn),
				.pin(irq_pin[g]),
				.rise_sel(st_reg.edge_irq[g]),
				.arm(st_reg.pmr_irq[g]),
				.clr(irq_clr[g]),
				.flag(irq_flag[g])
			);
		end
		for (g = 0; g < 8; g++) begin : pin_cells
			edge_flag u_pin (
				.pclk(pclk),
				.presetn(presetn),
				.pin(pin_event_pin[g]),
				.rise_sel(st_reg.edge_pin[g]),
				// pad level is watched, so a driven port edge counts too
				.arm(1'b1),
				.clr(pin_clr[g]),
				.flag(pin_flag[g])
			);
		end
	endgenerate

	assign elig_irq = irq_flag & st_reg.ien_irq;
	assign pin_any = |(pin_flag & st_reg.ien_pin);
	assign elig_int = st_reg.int_flag & st_reg.ien_int;
	assign pend_take = ((|elig_irq) | pin_any | (|elig_int)) & ~st_reg.mask_i;
	// a bus access counts as the instruction in flight, so a clear finishes first
	assign take = (st_reg.fsm == S_IDLE) & pend_take & insn_done & ~psel;
	assign wr = psel & penable & pwrite;

	always_comb begin
		st_next = st_reg;
		irq_clr = '0;
		pin_clr = '0;
		int_clr = '0;
		rd = '0;
		hit = 1'b1;
		case (paddr)
			OFF_REQ1: begin
				rd[7:0] = REQ1_FIXED | {st_reg.int_flag[INT_TB1], st_reg.int_flag[INT_TA],
					2'b00, irq_flag};
			end
			OFF_REQ2: begin
				rd[7:0] = {st_reg.int_flag[INT_DT], st_reg.int_flag[INT_AD], 1'b0,
					st_reg.int_flag[INT_S1], 4'h0};
			end
			OFF_PIN_FLAGS: begin
				rd[7:0] = pin_flag;
			end
			OFF_EN1: begin
				rd[7:0] = {st_reg.ien_int[INT_TB1], st_reg.ien_int[INT_TA], 2'b00,
					st_reg.ien_irq};
			end
			OFF_EN2: begin
				rd[7:0] = {st_reg.ien_int[INT_DT], st_reg.ien_int[INT_AD], 1'b0,
					st_reg.ien_int[INT_S1], 4'h0};
			end
			OFF_PIN_EN: begin
				rd[7:0] = st_reg.ien_pin;
			end
			OFF_IRQ_EDGE: begin
				rd[3:0] = st_reg.edge_irq;
			end
			OFF_PIN_EDGE: begin
				rd[7:0] = st_reg.edge_pin;
			end
			OFF_PORT_MODE: begin
				rd[3:0] = st_reg.pmr_irq;
			end
			OFF_CCR: begin
				rd[BIT_CCR_I] = st_reg.mask_i;
			end
			OFF_REQ_OTHER: begin
				rd[INT_N-INT_OTHER-1:0] = st_reg.int_flag[INT_N-1:INT_OTHER];
			end
			OFF_EN_OTHER: begin
				rd[INT_N-INT_OTHER-1:0] = st_reg.ien_int[INT_N-1:INT_OTHER];
			end
			OFF_STATUS: begin
				rd[BIT_BUSY] = (st_reg.fsm != S_IDLE);
				rd[4:0] = st_reg.vec;
			end
			default: begin
				hit = 1'b0;
			end
		endcase

		// read data and error are settled in the setup cycle
		if (psel && !penable) begin
			st_next.prdata = rd;
			st_next.pslverr = ~hit;
		end

		if (wr) begin
			case (paddr)
				OFF_REQ1: begin
					irq_clr = ~pwdata[3:0];
					int_clr[INT_TB1] = ~pwdata[BIT_TB1];
					int_clr[INT_TA] = ~pwdata[BIT_TA];
				end
				OFF_REQ2: begin
					int_clr[INT_DT] = ~pwdata[BIT_DT];
					int_clr[INT_AD] = ~pwdata[BIT_AD];
					int_clr[INT_S1] = ~pwdata[BIT_S1];
				end
				OFF_PIN_FLAGS: begin
					pin_clr = ~pwdata[7:0];
				end
				OFF_EN1: begin
					st_next.ien_int[INT_TB1] = pwdata[BIT_TB1];
					st_next.ien_int[INT_TA] = pwdata[BIT_TA];
					st_next.ien_irq = pwdata[3:0];
				end
				OFF_EN2: begin
					st_next.ien_int[INT_DT] = pwdata[BIT_DT];
					st_next.ien_int[INT_AD] = pwdata[BIT_AD];
					st_next.ien_int[INT_S1] = pwdata[BIT_S1];
				end
				OFF_PIN_EN: begin
					st_next.ien_pin = pwdata[7:0];
				end
				OFF_IRQ_EDGE: begin
					st_next.edge_irq = pwdata[3:0];
				end
				OFF_PIN_EDGE: begin
					st_next.edge_pin = pwdata[7:0];
				end
				OFF_PORT_MODE: begin
					st_next.pmr_irq = pwdata[3:0];
				end
				OFF_CCR: begin
					st_next.mask_i = pwdata[BIT_CCR_I];
				end
				OFF_REQ_OTHER: begin
					int_clr[INT_N-1:INT_OTHER] = ~pwdata[INT_N-INT_OTHER-1:0];
				end
				OFF_EN_OTHER: begin
					st_next.ien_int[INT_N-1:INT_OTHER] = pwdata[INT_N-INT_OTHER-1:0];
				end
				default: begin
				end
			endcase
		end

		// a request in the clearing cycle still lands
		st_next.int_flag = (st_reg.int_flag & ~int_clr) | periph_req;

		case (st_reg.fsm)
			S_IDLE: begin
				if (take) begin
					st_next.fsm = S_STACK;
					st_next.vec = pick(elig_irq, pin_any, elig_int);
					st_next.cnt = STACK_STATES - 3'h1;
				end
			end
			S_STACK: begin
				if (st_reg.cnt == 3'h0) begin
					// hardware mask set overrides a software write in the same cycle
					st_next.mask_i = 1'b1;
					st_next.fsm = S_VFETCH;
					st_next.cnt = VFETCH_STATES - 3'h1;
				end else begin
					st_next.cnt = st_reg.cnt - 3'h1;
				end
			end
			S_VFETCH: begin
				if (st_reg.cnt == 3'h0) begin
					st_next.fsm = S_IFETCH;
					st_next.cnt = IFETCH_STATES - 3'h1;
				end else begin
					st_next.cnt = st_reg.cnt - 3'h1;
				end
			end
			S_IFETCH: begin
				if (st_reg.cnt == 3'h0) begin
					st_next.fsm = S_INTERN;
					st_next.cnt = INTERN_STATES - 3'h1;
				end else begin
					st_next.cnt = st_reg.cnt - 3'h1;
				end
			end
			S_INTERN: begin
				if (st_reg.cnt == 3'h0) begin
					st_next.fsm = S_IDLE;
				end else begin
					st_next.cnt = st_reg.cnt - 3'h1;
				end
			end
			default: begin
				st_next.fsm = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= CTL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = st_reg.pslverr;
	assign exc_req = pend_take;
	assign exc.stack_pc = (st_reg.fsm == S_STACK) & (st_reg.cnt >= 3'h2);
	assign exc.stack_ccr = (st_reg.fsm == S_STACK) & (st_reg.cnt < 3'h2);
	assign exc.vec_fetch = (st_reg.fsm == S_VFETCH);
	assign exc.insn_fetch = (st_reg.fsm == S_IFETCH);
	assign exc.handler_go = (st_reg.fsm == S_INTERN) & (st_reg.cnt == 3'h0);
	assign exc.vector_no = st_reg.vec;
	// vectors are word sized, two bytes apart
	assign exc.vector_addr = {10'h000, st_reg.vec, 1'b0};

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_stack;
		(st_reg.fsm == S_STACK)[*4];
	endsequence
	sequence s_vfetch;
		(st_reg.fsm == S_VFETCH)[*2];
	endsequence
	sequence s_ifetch;
		(st_reg.fsm == S_IFETCH)[*4];
	endsequence
	sequence s_intern;
		(st_reg.fsm == S_INTERN)[*4];
	endsequence

	a_entry_steps: assert property (take |=>
		s_stack ##1 s_vfetch ##1 s_ifetch ##1 s_intern ##1 st_reg.fsm == S_IDLE)
		else $error("exception entry phase lengths wrong");
	a_mask_holds: assert property ((st_reg.mask_i && st_reg.fsm == S_IDLE) |=>
		st_reg.fsm == S_IDLE)
		else $error("request taken while masked");
	a_mask_set: assert property ((st_reg.fsm == S_STACK ##1 st_reg.fsm == S_VFETCH) |->
		st_reg.mask_i)
		else $error("mask not set after stacking");
	a_irq_first: assert property ((take && elig_irq[0]) |=> st_reg.vec == VEC_IRQ0)
		else $error("irq 0 not chosen first");
	a_pin_shared: assert property ((take && elig_irq == 4'h0 && pin_any) |=>
		st_reg.vec == VEC_PIN)
		else $error("edge pin vector not 8");
	a_vec_range: assert property ((st_reg.fsm != S_IDLE) |->
		(st_reg.vec >= VEC_IRQ0 && st_reg.vec <= VEC_INT_LAST))
		else $error("vector out of range");
	a_clear_first: assert property ((psel && st_reg.fsm == S_IDLE) |=> st_reg.fsm == S_IDLE)
		else $error("exception taken during bus access");
	a_req2_low: assert property ((psel && penable && !pwrite && paddr == OFF_REQ2) |->
		prdata[3:0] == 4'h0)
		else $error("reserved request bits not zero");
	// a legal clearing write right after the set may drop the flag
	a_serial_set: assert property (periph_req[INT_S1] |=>
		st_reg.int_flag[INT_S1] ##1 (st_reg.int_flag[INT_S1] || $past(wr)))
		else $error("serial done flag lost");
	a_flag_kept: assert property ((st_reg.int_flag[INT_S1] && !wr) |=> st_reg.int_flag[INT_S1])
		else $error("flag cleared without write");
endmodule

// *** hdl/eic_pkg.sv ***
package eic_pkg;
	localparam int ADDR_W = 8;
	localparam int INT_N = 21;
	localparam int INT_VEC_SPAN = 15;

	localparam logic [7:0] OFF_REQ1 = 8'h00;
	localparam logic [7:0] OFF_REQ2 = 8'h04;
	localparam logic [7:0] OFF_PIN_FLAGS = 8'h08;
	localparam logic [7:0] OFF_EN1 = 8'h0C;
	localparam logic [7:0] OFF_EN2 = 8'h10;
	localparam logic [7:0] OFF_PIN_EN = 8'h14;
	localparam logic [7:0] OFF_IRQ_EDGE = 8'h18;
	localparam logic [7:0] OFF_PIN_EDGE = 8'h1C;
	localparam logic [7:0] OFF_PORT_MODE = 8'h20;
	localparam logic [7:0] OFF_CCR = 8'h24;
	localparam logic [7:0] OFF_REQ_OTHER = 8'h28;
	localparam logic [7:0] OFF_EN_OTHER = 8'h2C;
	localparam logic [7:0] OFF_STATUS = 8'h30;

	localparam logic [7:0] REQ1_FIXED = 8'h10;
	localparam logic [7:0] PIN_FLAGS_RESET = 8'h00;
	localparam logic CCR_I_RESET = 1'b1;
	localparam int BIT_TB1 = 7;
	localparam int BIT_TA = 6;
	localparam int BIT_DT = 7;
	localparam int BIT_AD = 6;
	localparam int BIT_S1 = 4;
	localparam int BIT_CCR_I = 7;
	localparam int BIT_BUSY = 8;

	localparam int INT_TA = 0;
	localparam int INT_TB1 = 1;
	localparam int INT_S1 = 2;
	localparam int INT_AD = 3;
	localparam int INT_DT = 4;
	localparam int INT_OTHER = 5;

	localparam logic [4:0] VEC_IRQ0 = 5'h04;
	localparam logic [4:0] VEC_PIN = 5'h08;
	localparam logic [4:0] VEC_INT0 = 5'h09;
	localparam logic [4:0] VEC_INT_LAST = 5'h17;

	localparam logic [2:0] STACK_STATES = 3'h4;
	localparam logic [2:0] VFETCH_STATES = 3'h2;
	localparam logic [2:0] IFETCH_STATES = 3'h4;
	localparam logic [2:0] INTERN_STATES = 3'h4;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_STACK = 5'h02,
		S_VFETCH = 5'h04,
		S_IFETCH = 5'h08,
		S_INTERN = 5'h10
	} exc_state_t;

	typedef struct packed {
		logic stack_pc;
		logic stack_ccr;
		logic vec_fetch;
		logic insn_fetch;
		logic handler_go;
		logic [4:0] vector_no;
		logic [15:0] vector_addr;
	} exc_bus_t;
endpackage

// *** testbench/core_model.sv ***
`timescale 1ns/100ps
module core_model
	import eic_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire eic_pkg::exc_bus_t exc,
	output logic insn_done,
	output int entries,
	output logic [4:0] last_vec,
	output logic [15:0] last_addr,
	output int entry_len,
	output logic [15:0] phase_cnt
);
	int wait_n;
	int run;
	logic stk_d;
	// instruction lengths vary so entry is seen both prompt and late
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			insn_done <= 1'b0;
			wait_n <= 1;
			run <= 0;
			stk_d <= 1'b0;
			entries <= 0;
			last_vec <= 5'h00;
			last_addr <= 16'h0000;
			entry_len <= 0;
			phase_cnt <= 16'h0000;
		end else begin
			insn_done <= (wait_n == 1);
			wait_n <= (wait_n == 1) ? $urandom_range(13, 1) : wait_n - 1;
			stk_d <= exc.stack_pc;
			run <= (exc.stack_pc && !stk_d) ? 1 : run + 1;
			// one nibble per phase: pc, ccr, vector fetch, insn fetch
			phase_cnt <= (exc.stack_pc && !stk_d) ? 16'h1000 : phase_cnt + {3'h0, exc.stack_pc,
				3'h0, exc.stack_ccr, 3'h0, exc.vec_fetch, 3'h0, exc.insn_fetch};
			if (exc.handler_go) begin
				entries <= entries + 1;
				last_vec <= exc.vector_no;
				last_addr <= exc.vector_addr;
				entry_len <= run + 1;
			end
		end
	end
endmodule

// *** testbench/edge_interrupt_controller_tb_top.sv ***
`timescale 1ns/100ps
module edge_interrupt_controller_tb_top;
	import eic_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] irq_pin = 4'h0;
	logic [7:0] pin_event_pin = 8'h00;
	logic [INT_N-1:0] periph_req = '0;
	logic insn_done;
	logic exc_req;
	exc_bus_t exc;
	int entries;
	int entry_len;
	logic [4:0] last_vec;
	logic [15:0] last_addr;
	logic [15:0] phase_cnt;
	int ev;
	int err_total = 0;
	int n_compared = 0;
	int m_irq = 0;
	int m_pin = 0;
	int m_int = 0;
	logic [31:0] rd;
	logic se;
	logic [7:0] sel;
	logic [7:0] nv;
	logic [7:0] old;
	int n0;

	always #2.5 pclk = ~pclk;

	edge_interrupt_controller dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_pin(irq_pin), .pin_event_pin(pin_event_pin),
		.periph_req(periph_req), .insn_done(insn_done), .exc_req(exc_req), .exc(exc));
	core_model core_u (.pclk(pclk), .presetn(presetn), .exc(exc), .insn_done(insn_done),
		.entries(entries), .last_vec(last_vec), .last_addr(last_addr), .entry_len(entry_len),
		.phase_cnt(phase_cnt));

	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task fail(input string s);
		err_total++;
		$display("[FAIL] %0t %s", $time, s);
	endtask

	task chk_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		n_compared++;
		if ((got & m) !== (exp & m))
			fail($sformatf("read %h expected %h", got, exp));
	endtask

	task chk_entry(input int v);
		n_compared++;
		if (last_vec !== 5'(v) || last_addr !== 16'(v * 2) || entry_len != 14 ||
			phase_cnt !== 16'h2224)
			fail($sformatf("entry vec %h len %0d phases %h expected %h", last_vec, entry_len,
				phase_cnt, v));
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			fail("bus hang");
			complete_run();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk_reg(rd, exp, 32'h0000_00FF);
	endtask

	task drive(input logic [3:0] q, input logic [7:0] v);
		@(posedge pclk);
		irq_pin <= q;
		pin_event_pin <= v;
		repeat (6) @(posedge pclk);
	endtask

	task pulse(input int i);
		@(posedge pclk);
		periph_req[i] <= 1'b1;
		@(posedge pclk);
		periph_req[i] <= 1'b0;
		repeat (2) @(posedge pclk);
		m_int = m_int | (1 << i);
	endtask

	function automatic int prio(input int irq, input int pin, input int intl);
		for (int i = 0; i < 4; i++)
			if (irq[i])
				return VEC_IRQ0 + i;
		if (pin != 0)
			return VEC_PIN;
		for (int i = 0; i < INT_N; i++)
			if (intl[i])
				return (i >= 14) ? VEC_INT_LAST : VEC_INT0 + i;
		return 0;
	endfunction

	// enables only change while masked, the mask is set again by each entry
	task take(input int en1, input int pen, input int en2, input int ien);
		wr(OFF_EN1, en1);
		wr(OFF_PIN_EN, pen);
		wr(OFF_EN2, en2);
		wr(OFF_CCR, 32'h0000_0000);
		@(posedge pclk);
		chk_reg({31'h0, exc_req}, 32'h1, 32'h1);
		n0 = entries;
		for (int k = 0; k < 300 && entries == n0; k++)
			@(posedge pclk);
		if (entries == n0) begin
			fail("no entry");
			complete_run();
		end
		ev = prio(m_irq & en1, m_pin & pen, m_int & ien);
		chk_entry(ev);
		apb(1'b0, OFF_CCR, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0080, 32'h0000_0080);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk_reg(rd, ev, 32'h0000_01FF);
	endtask

	task quiet(input string s);
		n0 = entries;
		repeat (40) @(posedge pclk);
		chk_reg({31'h0, exc_req}, 32'h0, 32'h1);
		if (entries != n0)
			fail(s);
	endtask

	initial begin
		void'($urandom(94));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFF_PIN_FLAGS, 32'h0000_0000);
		rdc(OFF_REQ1, {24'h0, REQ1_FIXED});
		rdc(OFF_REQ2, 32'h0000_0000);
		apb(1'b0, OFF_CCR, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0080, 32'h0000_0080);
		apb(1'b0, 8'hFC, 32'h0000_0000);
		chk_reg({31'h0, se}, 32'h1, 32'h1);
		$display("test reset done");
		pulse(INT_S1);
		rdc(OFF_REQ2, 32'h1 << BIT_S1);
		wr(OFF_REQ2, 32'h0000_00FF);
		rdc(OFF_REQ2, 32'h1 << BIT_S1);
		wr(OFF_REQ2, 32'h0000_0000);
		rdc(OFF_REQ2, 32'h0000_0000);
		$display("test serial done");
		for (int i = 0; i < 6; i++) begin
			sel = 8'($urandom);
			nv = 8'($urandom);
			wr(OFF_PIN_EDGE, {24'h0, sel});
			wr(OFF_PIN_FLAGS, 32'h0000_0000);
			old = pin_event_pin;
			drive(irq_pin, nv);
			rdc(OFF_PIN_FLAGS, {24'h0, (~old & nv & sel) | (old & ~nv & ~sel)});
		end
		$display("test pin edges done");
		wr(OFF_IRQ_EDGE, 32'h0000_000F);
		wr(OFF_REQ1, 32'h0000_0000);
		drive(4'hF, pin_event_pin);
		rdc(OFF_REQ1, {24'h0, REQ1_FIXED});
		drive(4'h0, pin_event_pin);
		wr(OFF_PORT_MODE, 32'h0000_000F);
		drive(4'hF, pin_event_pin);
		rdc(OFF_REQ1, {24'h0, REQ1_FIXED} | 32'hF);
		m_irq = 15;
		$display("test irq done");
		wr(OFF_PIN_EDGE, 32'h0000_00FF);
		drive(4'hF, 8'h00);
		drive(4'hF, 8'hFF);
		m_pin = 255;
		pulse(INT_S1);
		take(32'h06, 0, 0, 0);
		take(32'h08, 0, 0, 0);
		take(0, 32'h24, 0, 0);
		take(0, 0, 32'h1 << BIT_S1, 1 << INT_S1);
		take(32'h0F, 32'hFF, 32'h1 << BIT_S1, 1 << INT_S1);
		pulse(INT_N - 1);
		wr(OFF_EN_OTHER, 32'h1 << (INT_N - 1 - INT_OTHER));
		take(0, 0, 0, 1 << (INT_N - 1));
		apb(1'b0, OFF_REQ_OTHER, 32'h0000_0000);
		chk_reg(rd, 32'h1 << (INT_N - 1 - INT_OTHER), 32'h0000_FFFF);
		rdc(OFF_REQ1, {24'h0, REQ1_FIXED} | 32'hF);
		rdc(OFF_PIN_FLAGS, 32'h0000_00FF);
		quiet("entry while masked");
		wr(OFF_EN1, 0);
		wr(OFF_PIN_EN, 0);
		wr(OFF_EN2, 0);
		wr(OFF_EN_OTHER, 0);
		wr(OFF_CCR, 32'h0000_0000);
		quiet("entry while disabled");
		$display("test entry done");
		complete_run();
	end
endmodule
